// ---- drc_pkg.sv ----
// Purpose: constants and carriers for the 4k x 1 dynamic memory controller
// Assumes: 100 MHz controller clock, 10 ns period
// Notes: timing figures in ns, refresh interval in tenths of ms, cycle counts derived from them
package drc_pkg;
  localparam int CLK_NS = 10;
  localparam int ADDR_W = 12;
  localparam int COL_W = 6;
  localparam int COL_COUNT = 64;
  // least times round up, longest round down
  localparam int ADDR_HOLD_NS = 75;
  localparam int ACCESS_NS = 180;
  localparam int STROBE_OFF_NS = 160;
  localparam int READ_HIGH_NS = 220;
  localparam int WE_DELAY_NS = 160;
  localparam int WE_WIDTH_NS = 180;
  localparam int DATA_HOLD_NS = 85;
  localparam int WRITE_HIGH_NS = 490;
  localparam int REFRESH_MS_X10 = 20;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int STROBE_OFF_CYC = (STROBE_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_HIGH_CYC = (READ_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_DELAY_CYC = (WE_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_WIDTH_CYC = (WE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // full array interval, longest time rounds down
  localparam int REFRESH_CYC = REFRESH_MS_X10 * 100000 / CLK_NS;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // user request carrier
  typedef struct packed {
    logic write;
    logic rmw;
    logic wdata;
    logic [ADDR_W-1:0] addr;
  } drc_req_t;
  // pins toward the memory
  typedef struct packed {
    logic strobe;
    logic refresh_sel;
    logic write_strobe;
    logic write_bit_in;
    logic [ADDR_W-1:0] addr;
  } drc_pins_t;
endpackage

// ---- drc_ctrl.sv ----
// Purpose: host controller driving a 4k x 1 dynamic memory through its pins
// Assumes: read data pin inverted and pulled high when undriven
// Notes: refresh requests win over user accesses between cycles
module drc_ctrl #(
  parameter int REFRESH_PERIOD = drc_pkg::REFRESH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire drc_pkg::drc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_data,
  output drc_pkg::drc_pins_t pins,
  input wire logic read_bit_n
);
  typedef enum {S_IDLE, S_HOLD, S_WAIT, S_WE, S_WEHI, S_TAIL, S_OFF} drc_state_t;

  // one spare slot per interval absorbs a refresh delayed by a running cycle
  localparam int SPACING = REFRESH_PERIOD / (drc_pkg::COL_COUNT + 1);
  // answer flag rises two edges past the access count, one spent leaving hold and one leaving wait
  localparam int RSP_LAG = drc_pkg::ACCESS_CYC + 2;

  drc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [31:0] ref_cnt_ff, nxt_ref_cnt;
  logic ref_due_ff, nxt_ref_due;
  logic [drc_pkg::COL_W-1:0] col_ff, nxt_col;
  logic is_ref_ff, nxt_is_ref;
  logic do_wr_ff, nxt_do_wr;
  logic rmw_ff, nxt_rmw;
  logic wbit_ff, nxt_wbit;
  drc_pkg::drc_pins_t pins_ff, nxt_pins;
  logic ready_ff, nxt_ready;
  logic rsp_v_ff, nxt_rsp_v;
  logic rsp_d_ff, nxt_rsp_d;
  logic rd_s1_ff, rd_s2_ff;
  logic [15:0] we_len_ff, nxt_we_len;

  // two-stage synchroniser on the read data pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_s1_ff <= 1'b1;
      rd_s2_ff <= 1'b1;
    end else begin
      rd_s1_ff <= read_bit_n;
      rd_s2_ff <= rd_s1_ff;
    end
  end

  // refresh interval timer, one column every spacing
  always_comb begin
    nxt_ref_cnt = ref_cnt_ff + 32'h00000001;
    nxt_ref_due = ref_due_ff;
    if (ref_cnt_ff >= 32'(SPACING - 1)) begin
      nxt_ref_cnt = 32'h00000000;
      nxt_ref_due = 1'b1;
    end else if (state_ff == S_IDLE && ref_due_ff) begin
      nxt_ref_due = 1'b0;
    end
  end

  // cycle sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_col = col_ff;
    nxt_is_ref = is_ref_ff;
    nxt_do_wr = do_wr_ff;
    nxt_rmw = rmw_ff;
    nxt_wbit = wbit_ff;
    nxt_pins = pins_ff;
    nxt_ready = 1'b0;
    nxt_rsp_v = 1'b0;
    nxt_rsp_d = rsp_d_ff;
    if (cnt_ff != drc_pkg::CNT_ZERO) begin
      nxt_cnt = cnt_ff - drc_pkg::CNT_ONE;
    end
    unique case (state_ff)
      S_IDLE: begin
        if (ref_due_ff) begin
          nxt_is_ref = 1'b1;
          nxt_do_wr = 1'b1;
          nxt_pins.refresh_sel = 1'b1;
          nxt_pins.addr = {{(drc_pkg::ADDR_W-drc_pkg::COL_W){1'b0}}, col_ff};
          nxt_pins.strobe = 1'b1;
          nxt_col = col_ff + 6'h01;
          nxt_cnt = 16'(drc_pkg::ADDR_HOLD_CYC);
          nxt_state = S_HOLD;
        end else if (req_valid && ready_ff) begin
          nxt_is_ref = 1'b0;
          nxt_do_wr = req.write | req.rmw;
          nxt_rmw = req.rmw;
          nxt_wbit = req.wdata;
          nxt_pins.refresh_sel = 1'b0;
          nxt_pins.addr = req.addr;
          nxt_pins.strobe = 1'b1;
          nxt_cnt = 16'(drc_pkg::ADDR_HOLD_CYC);
          nxt_state = S_HOLD;
        end else begin
          // offer ready only when no refresh will claim the next idle cycle
          nxt_ready = ~nxt_ref_due;
        end
      end
      S_HOLD: begin
        // select and address held past the strobe edge
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          nxt_state = S_WAIT;
          if (!do_wr_ff || rmw_ff) begin
            nxt_cnt = 16'(drc_pkg::ACCESS_CYC - drc_pkg::ADDR_HOLD_CYC);
          end else begin
            nxt_cnt = 16'(drc_pkg::WE_DELAY_CYC - drc_pkg::ADDR_HOLD_CYC);
          end
        end
      end
      S_WAIT: begin
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          if (!is_ref_ff && (!do_wr_ff || rmw_ff)) begin
            nxt_rsp_v = 1'b1;
            nxt_rsp_d = ~rd_s2_ff;
          end
          if (do_wr_ff) begin
            nxt_pins.write_bit_in = is_ref_ff ? 1'b0 : wbit_ff;
            nxt_pins.write_strobe = 1'b1;
            nxt_cnt = 16'(drc_pkg::WE_WIDTH_CYC);
            nxt_state = S_WE;
          end else begin
            // read holds write strobe low
            nxt_cnt = 16'(drc_pkg::READ_HIGH_CYC - drc_pkg::ACCESS_CYC);
            nxt_state = S_TAIL;
          end
        end
      end
      S_WE: begin
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          nxt_pins.write_strobe = 1'b0;
          nxt_cnt = 16'(drc_pkg::DATA_HOLD_CYC);
          nxt_state = S_WEHI;
        end
      end
      S_WEHI: begin
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          nxt_cnt = 16'(drc_pkg::WRITE_HIGH_CYC);
          nxt_state = S_TAIL;
        end
      end
      S_TAIL: begin
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          nxt_pins.strobe = 1'b0;
          nxt_pins.refresh_sel = 1'b0;
          nxt_cnt = 16'(drc_pkg::STROBE_OFF_CYC);
          nxt_state = S_OFF;
        end
      end
      S_OFF: begin
        if (cnt_ff == drc_pkg::CNT_ZERO) begin
          nxt_state = S_IDLE;
        end
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      cnt_ff <= drc_pkg::CNT_ZERO;
      ref_cnt_ff <= 32'h00000000;
      ref_due_ff <= 1'b0;
      col_ff <= 6'h00;
      is_ref_ff <= 1'b0;
      do_wr_ff <= 1'b0;
      rmw_ff <= 1'b0;
      wbit_ff <= 1'b0;
      pins_ff <= '0;
      ready_ff <= 1'b0;
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ref_cnt_ff <= nxt_ref_cnt;
      ref_due_ff <= nxt_ref_due;
      col_ff <= nxt_col;
      is_ref_ff <= nxt_is_ref;
      do_wr_ff <= nxt_do_wr;
      rmw_ff <= nxt_rmw;
      wbit_ff <= nxt_wbit;
      pins_ff <= nxt_pins;
      ready_ff <= nxt_ready;
      rsp_v_ff <= nxt_rsp_v;
      rsp_d_ff <= nxt_rsp_d;
    end
  end

  assign pins = pins_ff;
  assign req_ready = ready_ff;
  assign rsp_valid = rsp_v_ff;
  assign rsp_data = rsp_d_ff;

  // length of the running write strobe pulse, for the width check
  always_comb begin
    nxt_we_len = drc_pkg::CNT_ZERO;
    if (pins_ff.write_strobe) begin
      nxt_we_len = we_len_ff + drc_pkg::CNT_ONE;
    end
  end

  // register of the pulse length
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_len_ff <= drc_pkg::CNT_ZERO;
    end else begin
      we_len_ff <= nxt_we_len;
    end
  end

  // select must not drop while strobe is high in refresh
  sel_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pins_ff.strobe && pins_ff.refresh_sel) |=> (pins_ff.refresh_sel || !pins_ff.strobe))
    else $error("select dropped during refresh");
  // refresh drives only column bits
  ref_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_ff.strobe) && pins_ff.refresh_sel |-> pins_ff.addr[11:6] == 6'h00)
    else $error("refresh address has high bits");
  // column advances on each refresh start
  col_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_ff.strobe) && pins_ff.refresh_sel |-> col_ff == $past(col_ff) + 6'h01)
    else $error("column counter did not advance");
  // address stable while strobe high
  addr_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins_ff.strobe && $past(pins_ff.strobe) |-> $stable(pins_ff.addr))
    else $error("address changed during cycle");
  // write strobe only inside a strobed cycle
  we_inside_a: assert property (@(posedge clk) disable iff (!rst_n)
    pins_ff.write_strobe |-> pins_ff.strobe)
    else $error("write strobe outside cycle");
  // write strobe width at least the minimum
  we_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pins_ff.write_strobe) |-> we_len_ff >= 16'(drc_pkg::WE_WIDTH_CYC))
    else $error("write strobe too short");
  // read answer follows strobe rise by the access count plus two edges
  rd_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pins_ff.strobe) && !pins_ff.refresh_sel && !do_wr_ff |-> ##RSP_LAG rsp_v_ff)
    else $error("read answer late");
  // refresh cycles give no answer
  ref_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    is_ref_ff && state_ff != S_IDLE |-> !nxt_rsp_v)
    else $error("answer during refresh");
  // a due refresh seen while idle starts at the next edge
  ref_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    ref_due_ff && state_ff == S_IDLE |=> pins_ff.strobe && pins_ff.refresh_sel)
    else $error("refresh not started");
endmodule

// ---- drc_mem_model.sv ----
// Purpose: behavioural 4k x 1 dynamic memory facing the controller pins
// Assumes: read data line is open drain, pulled high when released
// Notes: counts refreshed columns and refresh gaps longer than the limit
module drc_mem_model #(
  parameter int ACC_NS = 150,
  parameter int LIMIT_NS = 65000
) (
  input wire drc_pkg::drc_pins_t pins,
  output logic read_bit_n,
  output int cols_seen,
  output int late_errs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem [0:4095];
  logic [11:0] lat_addr;
  logic cyc_sel;
  logic drive;
  realtime last [0:63];
  bit seen [0:63];
  // released line floats to the pull-up, driven level is inverted
  assign read_bit_n = drive ? ~mem[lat_addr] : 1'b1;
  initial begin
    drive = 1'b0;
    cols_seen = 0;
    late_errs = 0;
    for (int i = 0; i < 64; i++) begin
      last[i] = 0;
    end
  end
  // latch address and cycle type, refresh picks a column
  always @(posedge pins.strobe) begin
    lat_addr = pins.addr;
    cyc_sel = pins.refresh_sel;
    drive = 1'b0;
    if (cyc_sel) begin
      if ($realtime - last[lat_addr[5:0]] > LIMIT_NS) late_errs++;
      last[lat_addr[5:0]] = $realtime;
      if (!seen[lat_addr[5:0]]) cols_seen++;
      seen[lat_addr[5:0]] = 1'b1;
    end else begin
      #ACC_NS;
      if (pins.strobe && !pins.write_strobe) drive = 1'b1;
    end
  end
  // write strobe rise forces the line high, fall stores the bit outside refresh cycles
  always @(posedge pins.write_strobe) drive = 1'b0;
  always @(negedge pins.write_strobe) begin
    if (!cyc_sel) mem[lat_addr] = pins.write_bit_in;
  end
  always @(negedge pins.strobe) drive = 1'b0;
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for the dynamic memory controller
// Assumes: partner memory model on the pins, shortened refresh period
// Notes: inputs change at the falling clock edge
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RP = 16000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  drc_pkg::drc_req_t req = '0;
  logic req_ready, rsp_valid, rsp_data, read_bit_n;
  drc_pkg::drc_pins_t pins;
  int cols_seen, late_errs;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [11:0] addrs [0:4] = '{12'h000, 12'hfff, 12'h555, 12'haaa, 12'h03f};
  always #5 clk = ~clk;
  drc_ctrl #(.REFRESH_PERIOD(RP)) uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .pins(pins), .read_bit_n(read_bit_n));
  drc_mem_model #(.LIMIT_NS(RP * 10)) mem_m (.pins(pins), .read_bit_n(read_bit_n),
    .cols_seen(cols_seen), .late_errs(late_errs));
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hold the request until it is taken, then release it
  task issue(input logic wr, input logic rmw, input logic wd, input logic [11:0] a);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{write: wr, rmw: rmw, wdata: wd, addr: a};
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    if (req_ready !== 1'b1) mismatches++;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task wait_rsp(input string what, input logic exp);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (rsp_valid !== 1'b1) mismatches++;
    check(what, {31'h0, rsp_data}, {31'h0, exp});
  endtask
  // writes to corner addresses, then reads back, then overwrite
  task t_write_read;
    for (int i = 0; i < 5; i++) issue(1'b1, 1'b0, i[0], addrs[i]);
    for (int i = 0; i < 5; i++) begin
      issue(1'b0, 1'b0, 1'b0, addrs[i]);
      wait_rsp("read data", i[0]);
    end
    issue(1'b1, 1'b0, 1'b1, 12'h000);
    issue(1'b0, 1'b0, 1'b0, 12'h000);
    wait_rsp("overwrite", 1'b1);
  endtask
  // read-modify-write returns old bit and stores new one
  task t_rmw;
    issue(1'b1, 1'b1, 1'b1, 12'h555);
    wait_rsp("rmw old", 1'b0);
    issue(1'b0, 1'b0, 1'b0, 12'h555);
    wait_rsp("rmw new", 1'b1);
  endtask
  // idle over a full period: every column refreshed in time, data kept
  task t_refresh;
    repeat (RP + RP / 8) @(negedge clk);
    check("columns", cols_seen, 32'd64);
    check("late refresh", late_errs, 32'd0);
    issue(1'b0, 1'b0, 1'b0, 12'hfff);
    wait_rsp("retained", 1'b1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    check("pins in reset", pins, '0);
    rst_n = 1'b1;
    t_write_read;
    t_rmw;
    t_refresh;
    close_out;
  end
endmodule
